// >>> verilog/aais_core.sv
// Purpose: function selection and scaling of the auxiliary analog input
// Assumes: samples arrive from an asynchronous converter, 0x000..full scale
// Notes:   reference percentages are carried in hundredths of a percent; gain and bias settings in whole percent
//
// Behaviour
// [RQ1] function zero: aux input affects nothing
// [RQ2] conflict error when aux input doubly claimed
// [RQ3] setting error: PID enabled with aux function
// [RQ4] function one: aux replaces second preset
// [RQ5] step inputs choose main or aux reference
// [RQ6] aux reference mode ignores stored second preset
// [RQ7] function two: main gain scaled 0x-2x
// [RQ8] function three: main bias +-bias_span
// [RQ9] function four: output voltage bias 0-100 V
// [RQ10] gain multiplies main gain, bias adds
// [RQ11] type select picks voltage or current channel
// [RQ12] software sets bias_span relative to max_frequency
// [RQ13] positive gain: (input plus bias) times gain
// [RQ14] negative gain: 100 minus that product
// [RQ15] 10 V or 20 mA is full scale
// [RQ16] frequency use scales by max_frequency
// [RQ17] negative reference clamps to zero
// [RQ18] gain -255..255 percent, default 100
// [RQ19] bias -100..100 percent, default 0
// [RQ20] only chosen channel's gain and bias apply
//
// Decided for this implementation: the plain strobed port.
`include "aais_cfg.svh"

module aais_core
   import aais_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic [11:0] i_volt_sample,
   input  wire logic [11:0] i_curr_sample,
   input  wire logic [7:0]  i_reference_source_select,
   input  wire logic [7:0]  i_pid_feedback_source,
   input  wire logic [7:0]  i_pid_control_select,
   input  wire logic [15:0] i_max_frequency,
   input  wire logic [15:0] i_main_reference_gain,
   input  wire logic [15:0] i_main_reference_bias,
   input  wire logic [15:0] i_main_analog_freq,
   input  wire logic [15:0] i_preset_reference_two,
   input  wire logic [15:0] i_other_step_freq,
   input  wire logic [3:0]  i_step_select,
   input  wire logic [15:0] i_vf_voltage,
   output logic      [15:0] o_aux_freq,
   output logic      [15:0] o_speed_ref,
   output logic      [15:0] o_main_gain_eff,
   output logic      [15:0] o_main_bias_eff,
   output logic      [15:0] o_out_voltage,
   output logic             o_setting_conflict_error,
   output logic             o_pid_setting_error
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic signed [31:0] aais_sext(input logic [15:0] v);
      aais_sext = {{16{v[15]}}, v};
   endfunction : aais_sext

   function automatic logic signed [31:0] aais_abs(input logic signed [31:0] v);
      aais_abs = (v < 0) ? -v : v;
   endfunction : aais_abs

   // accepts a signed setting only inside +-lim
   function automatic logic aais_in_range(input logic [15:0] v,
                                          input logic [15:0] lim);
      aais_in_range = aais_abs(aais_sext(v)) <= aais_sext(lim);
   endfunction : aais_in_range

   // setting of the channel that input_type_select names; the other is never read
   function automatic logic [15:0] aais_pick(input logic        sel,
                                             input logic [15:0] volt_val,
                                             input logic [15:0] curr_val);
      aais_pick = sel ? curr_val : volt_val;
   endfunction : aais_pick

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0]   vgain_ff;
   logic [15:0]   vbias_ff;
   logic [15:0]   cgain_ff;
   logic [15:0]   cbias_ff;
   aais_func_type func_ff;
   logic          type_ff;
   logic [15:0]   span_ff;
   logic [15:0]   rdata_ff;
   logic [15:0]   nxt_rdata;

   // gain and bias may change while running; out-of-range writes are dropped
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         vgain_ff <= `AAIS_GAIN_RST; // RQ18
         vbias_ff <= `AAIS_BIAS_RST; // RQ19
         cgain_ff <= `AAIS_GAIN_RST; // RQ18
         cbias_ff <= `AAIS_BIAS_RST; // RQ19
      end else if (i_wr) begin
         if (i_addr == `AAIS_ADR_VGAIN && aais_in_range(i_wdata, `AAIS_GAIN_MAX)) begin
            vgain_ff <= i_wdata; // RQ18
         end else if (i_addr == `AAIS_ADR_VBIAS && aais_in_range(i_wdata, `AAIS_BIAS_MAX)) begin
            vbias_ff <= i_wdata; // RQ19
         end else if (i_addr == `AAIS_ADR_CGAIN && aais_in_range(i_wdata, `AAIS_GAIN_MAX)) begin
            cgain_ff <= i_wdata; // RQ18
         end else if (i_addr == `AAIS_ADR_CBIAS && aais_in_range(i_wdata, `AAIS_BIAS_MAX)) begin
            cbias_ff <= i_wdata; // RQ19
         end
      end
   end

   // the status and aux value offsets are read-only; writes there fall through
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         func_ff <= aais_func_type'(`AAIS_FUNC_RST);
         type_ff <= 1'b0;
         span_ff <= `AAIS_SPAN_RST;
      end else if (i_wr) begin
         if (i_addr == `AAIS_ADR_FUNC && i_wdata <= `AAIS_FUNC_MAX) begin
            func_ff <= aais_func_type'(i_wdata[2:0]);
         end else if (i_addr == `AAIS_ADR_TYPE && i_wdata <= `AAIS_TYPE_MAX) begin
            type_ff <= i_wdata[0];
         end else if (i_addr == `AAIS_ADR_SPAN && i_wdata <= `AAIS_SPAN_MAX) begin
            span_ff <= i_wdata; // RQ12
         end
      end
   end

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // each word is captured whole; a code caught mid-change may be off for a cycle
   logic [11:0] volt_meta_ff;
   logic [11:0] volt_ff;
   logic [11:0] curr_meta_ff;
   logic [11:0] curr_ff;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         volt_meta_ff <= 12'h000;
         volt_ff      <= 12'h000;
         curr_meta_ff <= 12'h000;
         curr_ff      <= 12'h000;
      end else begin
         volt_meta_ff <= i_volt_sample;
         volt_ff      <= volt_meta_ff;
         curr_meta_ff <= i_curr_sample;
         curr_ff      <= curr_meta_ff;
      end
   end

   // ----------------------------------------
   // channel scaling
   // ----------------------------------------
   logic [11:0]        in_code;
   logic signed [31:0] in_pct;
   logic signed [31:0] ch_gain;
   logic signed [31:0] ch_bias;
   logic signed [31:0] sum_pct;
   logic signed [31:0] prod_pct;
   logic signed [31:0] raw_ref;
   logic signed [31:0] aux_ref;

   always_comb begin
      // the unused channel is never looked at
      in_code = type_ff ? curr_ff : volt_ff; // RQ11
      if (in_code > `AAIS_ADC_FULL) begin
         in_code = `AAIS_ADC_FULL;
      end
      // full-scale code stands for 10 V or 20 mA
      in_pct   = ($signed({20'h00000, in_code}) * `AAIS_PCT_FULL)
                 / $signed({20'h00000, `AAIS_ADC_FULL}); // RQ15
      ch_gain  = aais_sext(aais_pick(type_ff, vgain_ff, cgain_ff)); // RQ20
      ch_bias  = aais_sext(aais_pick(type_ff, vbias_ff, cbias_ff)); // RQ20
      sum_pct  = in_pct + ch_bias * `AAIS_PCT_UNIT;
      // integer division truncates toward zero; finer than a hundredth is lost
      prod_pct = (sum_pct * aais_abs(ch_gain)) / `AAIS_PCT_UNIT; // RQ13
      if (ch_gain < 0) begin
         raw_ref = `AAIS_PCT_FULL - prod_pct; // RQ14
      end else begin
         raw_ref = prod_pct; // RQ13
      end
      aux_ref = (raw_ref < 0) ? 32'sh0 : raw_ref; // RQ17
   end

   // ----------------------------------------
   // setting checks
   // ----------------------------------------
   // errors only flag the setting; the chosen function keeps working meanwhile
   logic aux_claimed;
   logic src_aux;
   logic pidfb_aux;
   logic conflict;
   logic pid_err;
   logic freq_use;

   always_comb begin
      aux_claimed = func_ff != AAIS_FN_OFF;
      src_aux     = i_reference_source_select == `AAIS_SRC_AUX_V
                    || i_reference_source_select == `AAIS_SRC_AUX_I;
      pidfb_aux   = i_pid_feedback_source == `AAIS_PIDFB_AUX_V
                    || i_pid_feedback_source == `AAIS_PIDFB_AUX_I;
      conflict    = aux_claimed && (src_aux || pidfb_aux); // RQ2
      pid_err     = aux_claimed && i_pid_control_select != `AAIS_PID_OFF; // RQ3
      freq_use    = src_aux || func_ff == AAIS_FN_AUXREF; // RQ16
   end

   // ----------------------------------------
   // uses of the reference
   // ----------------------------------------
   logic signed [31:0] freq_full;
   logic signed [31:0] gain_full;
   logic signed [31:0] bias_full;
   logic signed [31:0] volt_full;
   logic [15:0]        nxt_aux_freq;
   logic [15:0]        nxt_speed_ref;
   logic [15:0]        nxt_main_gain;
   logic [15:0]        nxt_main_bias;
   logic [15:0]        nxt_out_voltage;

   always_comb begin
      freq_full = (aux_ref * $signed({16'h0000, i_max_frequency}))
                  / `AAIS_PCT_FULL; // RQ16
      // 0 % -> 0x, 100 % -> 2x of the main gain
      gain_full = (aais_sext(i_main_reference_gain) * aux_ref * 2)
                  / `AAIS_PCT_FULL; // RQ7
      // 0 % -> -span, 100 % -> +span
      bias_full = aais_sext(i_main_reference_bias)
                  + ((aux_ref - `AAIS_PCT_HALF) * 2 * $signed({16'h0000, span_ff}))
                  / `AAIS_PCT_FULL; // RQ8
      // output in tenths of a volt: 100 % -> 100.0 V
      volt_full = aais_sext(i_vf_voltage) + aux_ref / `AAIS_VOLT_DIV; // RQ9

      nxt_aux_freq    = freq_use ? freq_full[15:0] : 16'h0000;
      nxt_main_gain   = i_main_reference_gain;
      nxt_main_bias   = i_main_reference_bias;
      nxt_out_voltage = i_vf_voltage;
      case (func_ff)
         AAIS_FN_GAIN: begin
            nxt_main_gain = gain_full[15:0]; // RQ10
         end
         AAIS_FN_BIAS: begin
            nxt_main_bias = bias_full[15:0]; // RQ10
         end
         AAIS_FN_VBIAS: begin
            nxt_out_voltage = volt_full[15:0]; // RQ9
         end
         default: begin
            // functions zero and one leave main gain, main bias and output voltage untouched
            nxt_main_gain = i_main_reference_gain; // RQ1
         end
      endcase
   end

   // ----------------------------------------
   // multi-step speed selection
   // ----------------------------------------
   // step 0 is the main analog reference, step 1 the second reference;
   // in aux reference mode the stored second preset is never looked at
   always_comb begin
      if (i_step_select == `AAIS_STEP_MAIN) begin
         nxt_speed_ref = i_main_analog_freq; // RQ5
      end else if (i_step_select == `AAIS_STEP_SECOND) begin
         if (func_ff == AAIS_FN_AUXREF) begin
            nxt_speed_ref = freq_full[15:0]; // RQ4 RQ6
         end else begin
            nxt_speed_ref = i_preset_reference_two;
         end
      end else begin
         nxt_speed_ref = i_other_step_freq;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_aux_freq               <= 16'h0000;
         o_speed_ref              <= 16'h0000;
         o_main_gain_eff          <= 16'h0000;
         o_main_bias_eff          <= 16'h0000;
         o_out_voltage            <= 16'h0000;
         o_setting_conflict_error <= 1'b0;
         o_pid_setting_error      <= 1'b0;
      end else begin
         o_aux_freq               <= nxt_aux_freq;
         o_speed_ref              <= nxt_speed_ref;
         o_main_gain_eff          <= nxt_main_gain;
         o_main_bias_eff          <= nxt_main_bias;
         o_out_voltage            <= nxt_out_voltage;
         o_setting_conflict_error <= conflict; // RQ2
         o_pid_setting_error      <= pid_err; // RQ3
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   always_comb begin
      nxt_rdata = 16'h0000;
      if (i_addr == `AAIS_ADR_VGAIN) begin
         nxt_rdata = vgain_ff;
      end else if (i_addr == `AAIS_ADR_VBIAS) begin
         nxt_rdata = vbias_ff;
      end else if (i_addr == `AAIS_ADR_CGAIN) begin
         nxt_rdata = cgain_ff;
      end else if (i_addr == `AAIS_ADR_CBIAS) begin
         nxt_rdata = cbias_ff;
      end else if (i_addr == `AAIS_ADR_FUNC) begin
         nxt_rdata = {13'h0000, func_ff};
      end else if (i_addr == `AAIS_ADR_TYPE) begin
         nxt_rdata = {15'h0000, type_ff};
      end else if (i_addr == `AAIS_ADR_SPAN) begin
         nxt_rdata = span_ff;
      end else if (i_addr == `AAIS_ADR_STATUS) begin
         nxt_rdata[`AAIS_ST_CONFLICT] = o_setting_conflict_error;
         nxt_rdata[`AAIS_ST_PIDERR]   = o_pid_setting_error;
         nxt_rdata[`AAIS_ST_FREQUSE]  = freq_use;
      end else if (i_addr == `AAIS_ADR_AUXVAL) begin
         // clamped reference, hundredths of a percent
         nxt_rdata = aux_ref[15:0];
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rdata_ff <= 16'h0000;
      end else if (i_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign o_rdata = rdata_ff;

endmodule : aais_core

// >>> include/aais_cfg.svh
// Purpose: constants of the auxiliary analog input scaler
// Assumes: registers are 16 bits wide and addressed by their printed offsets
// Notes:   definitions only
`ifndef AAIS_CFG_SVH
`define AAIS_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AAIS_ADR_VGAIN    16'h0144
`define AAIS_ADR_VBIAS    16'h0145
`define AAIS_ADR_CGAIN    16'h0147
`define AAIS_ADR_CBIAS    16'h0148
`define AAIS_ADR_FUNC     16'h014D
`define AAIS_ADR_TYPE     16'h014E
`define AAIS_ADR_SPAN     16'h014F
`define AAIS_ADR_STATUS   16'h0150
`define AAIS_ADR_AUXVAL   16'h0151

// ----------------------------------------
// reset values and setting limits
// ----------------------------------------
`define AAIS_GAIN_RST     16'h0064
`define AAIS_BIAS_RST     16'h0000
`define AAIS_FUNC_RST     16'h0000
`define AAIS_TYPE_RST     16'h0000
`define AAIS_SPAN_RST     16'h000A
`define AAIS_GAIN_MAX     16'h00FF
`define AAIS_BIAS_MAX     16'h0064
`define AAIS_FUNC_MAX     16'h0004
`define AAIS_TYPE_MAX     16'h0001
`define AAIS_SPAN_MAX     16'h0032

// ----------------------------------------
// scaling, codes and status bits
// ----------------------------------------
`define AAIS_ADC_FULL     12'hFA0
`define AAIS_PCT_FULL     32'sh00002710
`define AAIS_PCT_HALF     32'sh00001388
`define AAIS_PCT_UNIT     32'sh00000064
`define AAIS_VOLT_DIV     32'sh0000000A
`define AAIS_SRC_AUX_V    8'h07
`define AAIS_SRC_AUX_I    8'h08
`define AAIS_PIDFB_AUX_V  8'h05
`define AAIS_PIDFB_AUX_I  8'h06
`define AAIS_STEP_MAIN    4'h0
`define AAIS_STEP_SECOND  4'h1
`define AAIS_PID_OFF      8'h00
`define AAIS_ST_CONFLICT  0
`define AAIS_ST_PIDERR    1
`define AAIS_ST_FREQUSE   2

`endif

// >>> include/aais_pkg.sv
// Purpose: types of the auxiliary analog input scaler
// Assumes: nothing
// Notes:   codes follow declaration order
package aais_pkg;
   typedef enum logic [2:0] {
      AAIS_FN_OFF,
      AAIS_FN_AUXREF,
      AAIS_FN_GAIN,
      AAIS_FN_BIAS,
      AAIS_FN_VBIAS
   } aais_func_type;
endpackage : aais_pkg

// >>> tb/aais_core_monitor.sv
// Purpose: port-level checks of the aux analog input scaler
// Assumes: the function is only ever set through the register bus
// Notes:   func_ff shadows legal writes; checks wait until it is stable
`include "aais_cfg.svh"
module aais_core_monitor
   import aais_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic [7:0]  i_reference_source_select,
   input wire logic [7:0]  i_pid_feedback_source,
   input wire logic [7:0]  i_pid_control_select,
   input wire logic [15:0] i_main_reference_gain,
   input wire logic [15:0] i_preset_reference_two,
   input wire logic [3:0]  i_step_select,
   input wire logic [15:0] i_vf_voltage,
   input wire logic [15:0] o_aux_freq,
   input wire logic [15:0] o_speed_ref,
   input wire logic [15:0] o_main_gain_eff,
   input wire logic [15:0] o_out_voltage,
   input wire logic        o_setting_conflict_error,
   input wire logic        o_pid_setting_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [1:0]  warm_ff;
   logic [15:0] func_ff;
   logic [15:0] func_prev_ff;
   logic        aux_src;
   logic        claim;
   logic        ok;
   assign aux_src = (i_reference_source_select == `AAIS_SRC_AUX_V) || (i_reference_source_select == `AAIS_SRC_AUX_I);
   assign claim   = aux_src
                    || (i_pid_feedback_source == `AAIS_PIDFB_AUX_V)
                    || (i_pid_feedback_source == `AAIS_PIDFB_AUX_I);
   // outputs lag settings, so only judge once reset and func have settled
   assign ok      = (warm_ff == 2'h3) && (func_ff == func_prev_ff);
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         warm_ff <= 2'h0;
      end else if (warm_ff != 2'h3) begin
         warm_ff <= warm_ff + 2'h1;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         func_ff      <= 16'h0000;
         func_prev_ff <= 16'h0000;
      end else begin
         func_prev_ff <= func_ff;
         if (i_wr && i_addr == `AAIS_ADR_FUNC && i_wdata <= `AAIS_FUNC_MAX) begin
            func_ff <= i_wdata;
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_conflict_flag: assert property (ok |->
      o_setting_conflict_error == (func_ff != 16'h0000 && $past(claim)))
      else $error("conflict flag wrong");
   a_pid_flag: assert property (ok |->
      o_pid_setting_error == (func_ff != 16'h0000 && $past(i_pid_control_select) != 8'h00))
      else $error("pid setting flag wrong");
   a_speed_is_aux: assert property (ok && func_ff == 16'h0001 && $past(i_step_select) == 4'h1
      && $stable(o_aux_freq) |-> o_speed_ref == o_aux_freq)
      else $error("speed ref not aux frequency");
   a_preset_used: assert property (ok && func_ff != 16'h0001 && $past(i_step_select) == 4'h1
      |-> o_speed_ref == $past(i_preset_reference_two))
      else $error("second preset not used");
   a_aux_freq_off: assert property (ok && func_ff != 16'h0001 && !$past(aux_src) |-> o_aux_freq == 16'h0000)
      else $error("aux frequency not zero");
   a_gain_pass: assert property (ok && func_ff != 16'h0002 |->
      o_main_gain_eff == $past(i_main_reference_gain))
      else $error("main gain altered");
   a_volt_pass: assert property (ok && func_ff != 16'h0004 |-> o_out_voltage == $past(i_vf_voltage))
      else $error("output voltage altered");
   a_vbias_floor: assert property (ok && func_ff == 16'h0004 |-> o_out_voltage >= $past(i_vf_voltage))
      else $error("voltage bias negative");
   c_aux_ref: cover property (ok && func_ff == 16'h0001 && o_speed_ref != 16'h0000);
   c_conflict: cover property (o_setting_conflict_error);
   c_vbias: cover property (ok && func_ff == 16'h0004 && o_out_voltage > i_vf_voltage);
endmodule : aais_core_monitor

bind aais_core aais_core_monitor u_mon (.*);

// >>> tb/aais_src.sv
// Purpose: analog source model feeding both converter channels
// Assumes: codes change a few ns after the clock, as an async converter
// Notes:   the deselected channel carries a changing pattern
module aais_src (
   input  wire logic        i_core_clk,
   input  wire logic        i_use_curr,
   input  wire logic [11:0] i_code,
   output logic      [11:0] o_volt_sample = 12'h000,
   output logic      [11:0] o_curr_sample = 12'h000
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] noise = 12'h5A5;
   always @(posedge i_core_clk) begin
      #3;
      noise = noise + 12'h3C7;
      o_volt_sample = i_use_curr ? noise : i_code;
      o_curr_sample = i_use_curr ? i_code : noise;
   end
endmodule : aais_src

// >>> tb/aais_core_tb.sv
// Purpose: self-checking bench of the aux analog input scaler
// Assumes: aux_ref is read back at its own offset
// Notes:   expected figures use 0xFA0 as full scale
`include "aais_cfg.svh"
module aais_core_tb;
   import aais_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_use_curr = 1'b0;
   logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, i_max_frequency = 16'h1770;
   logic [15:0] i_main_reference_gain = 16'h0032, i_main_reference_bias = 16'h0005, i_main_analog_freq = 16'h0111;
   logic [15:0] i_preset_reference_two = 16'h0222, i_other_step_freq = 16'h0333, i_vf_voltage = 16'h0200;
   logic [15:0] o_rdata, o_aux_freq, o_speed_ref, o_main_gain_eff, o_main_bias_eff, o_out_voltage;
   logic [11:0] i_volt_sample, i_curr_sample, src_code = 12'h000;
   logic [7:0]  i_reference_source_select = 8'h00, i_pid_feedback_source = 8'h00, i_pid_control_select = 8'h00;
   logic [3:0]  i_step_select = 4'h0;
   logic        o_setting_conflict_error, o_pid_setting_error;
   int          err_count = 0;
   int          samples_checked = 0;
   always #5 i_core_clk = ~i_core_clk;
   aais_core DUT (.*);
   aais_src u_src (.i_core_clk(i_core_clk), .i_use_curr(i_use_curr), .i_code(src_code),
                   .o_volt_sample(i_volt_sample), .o_curr_sample(i_curr_sample));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask : wr
   task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1;
      chk(nm, exp, o_rdata);
   endtask : rd_chk
   // sample changes take three edges; six leaves margin
   task automatic settle();
      repeat (6) @(posedge i_core_clk);
      #1;
   endtask : settle
   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [15:0] adr [8] = '{16'h0144, 16'h0145, 16'h0147, 16'h0148, 16'h014D, 16'h014E, 16'h014F, 16'h01FF};
      logic [15:0] exp [8] = '{16'h0064, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h000A, 16'h0000};
      for (int k = 0; k < 8; k++) begin
         rd_chk("reset_value", adr[k], exp[k]);
      end
      wr(`AAIS_ADR_VGAIN, 16'h0100);
      rd_chk("gain_limit", `AAIS_ADR_VGAIN, 16'h0064);
      wr(`AAIS_ADR_VBIAS, 16'hFF9B);
      rd_chk("bias_limit", `AAIS_ADR_VBIAS, 16'h0000);
   endtask : t_regs
   task automatic t_funcs();
      @(posedge i_core_clk);
      i_step_select <= 4'h1;
      src_code      <= 12'hFA0;
      settle();
      chk("speed_off", 16'h0222, o_speed_ref);
      chk("gain_off", 16'h0032, o_main_gain_eff);
      chk("bias_off", 16'h0005, o_main_bias_eff);
      chk("afreq_off", 16'h0000, o_aux_freq);
      wr(`AAIS_ADR_FUNC, 16'h0001);
      i_preset_reference_two <= 16'h0444;
      settle();
      chk("afreq_aux", 16'h1770, o_aux_freq);
      chk("speed_aux", 16'h1770, o_speed_ref);
      @(posedge i_core_clk);
      i_step_select <= 4'h0;
      settle();
      chk("speed_main", 16'h0111, o_speed_ref);
      @(posedge i_core_clk);
      i_step_select <= 4'h2;
      settle();
      chk("speed_other", 16'h0333, o_speed_ref);
      wr(`AAIS_ADR_FUNC, 16'h0002);
      settle();
      chk("gain_mod", 16'h0064, o_main_gain_eff);
      wr(`AAIS_ADR_SPAN, 16'h0014);
      wr(`AAIS_ADR_FUNC, 16'h0003);
      settle();
      chk("bias_mod", 16'h0019, o_main_bias_eff);
      wr(`AAIS_ADR_FUNC, 16'h0004);
      settle();
      chk("volt_full", 16'h05E8, o_out_voltage);
      @(posedge i_core_clk);
      src_code <= 12'h7D0;
      settle();
      chk("volt_half", 16'h03F4, o_out_voltage);
   endtask : t_funcs
   task automatic t_errors();
      wr(`AAIS_ADR_FUNC, 16'h0001);
      for (int k = 0; k < 4; k++) begin
         @(posedge i_core_clk);
         i_reference_source_select <= (k < 2) ? 8'h07 + 8'(k) : 8'h00;
         i_pid_feedback_source     <= (k < 2) ? 8'h00 : 8'h03 + 8'(k);
         settle();
         chk("conflict", 16'h0001, {15'h0000, o_setting_conflict_error});
      end
      rd_chk("status", `AAIS_ADR_STATUS, 16'h0005);
      @(posedge i_core_clk);
      i_pid_feedback_source <= 8'h00;
      i_pid_control_select  <= 8'h01;
      settle();
      chk("conflict_clr", 16'h0000, {15'h0000, o_setting_conflict_error});
      chk("pid_err", 16'h0001, {15'h0000, o_pid_setting_error});
      rd_chk("status_pid", `AAIS_ADR_STATUS, 16'h0006);
      wr(`AAIS_ADR_FUNC, 16'h0000);
      settle();
      chk("pid_clr", 16'h0000, {15'h0000, o_pid_setting_error});
      @(posedge i_core_clk);
      i_pid_control_select <= 8'h00;
   endtask : t_errors
   task automatic chan(input logic [15:0] ga, input logic [15:0] g, input logic [15:0] b, input logic [15:0] exp);
      wr(ga, g);
      wr(ga + 16'h0001, b);
      settle();
      rd_chk("aux_ref", `AAIS_ADR_AUXVAL, exp);
   endtask : chan
   task automatic t_chan();
      chan(`AAIS_ADR_VGAIN, 16'h00C8, 16'h000A, 16'h2EE0);
      chan(`AAIS_ADR_VGAIN, 16'hFFCE, 16'h0000, 16'h1D4C);
      chan(`AAIS_ADR_VGAIN, 16'h0064, 16'hFF9C, 16'h0000);
      wr(`AAIS_ADR_TYPE, 16'h0001);
      i_use_curr <= 1'b1;
      chan(`AAIS_ADR_CGAIN, 16'h0064, 16'h0000, 16'h1388);
      chan(`AAIS_ADR_CGAIN, 16'hFFEC, 16'h0000, 16'h2328);
   endtask : t_chan
   initial begin
      repeat (5000) @(posedge i_core_clk);
      err_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_regs();
      t_funcs();
      t_errors();
      t_chan();
      results();
   end
endmodule : aais_core_tb
